/* File: design/pps_top.sv */
/*
  peripheral pin selection with key-guarded lock and one-shot lock option.
  assumes software writes are one-cycle strobes synchronous to clock_i; a separate
  power-on reset input clears selections, rst_n_i alone does not.
*/
`include "pps_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pps_top #(
  parameter int NUM_PINS = 18,
  parameter int NUM_SRCS = 33,
  parameter int NUM_INPUTS = 8
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire logic one_shot_lock_config_i,
  input wire logic sleep_i,
  input wire logic lock_wr_i,
  input wire logic [7:0] lock_wdata_i,
  input wire logic out_sel_wr_i,
  input wire logic [$clog2(NUM_PINS)-1:0] out_sel_idx_i,
  input wire logic [5:0] out_sel_wdata_i,
  input wire logic in_sel_wr_i,
  input wire logic [$clog2(NUM_INPUTS)-1:0] in_sel_idx_i,
  input wire logic [4:0] in_sel_wdata_i,
  input wire logic [NUM_SRCS-1:0] periph_out_i,
  input wire logic [NUM_SRCS-1:0] periph_oe_ovr_i,
  input wire logic [NUM_SRCS-1:0] periph_oe_val_i,
  input wire logic [NUM_PINS-1:0] pin_direction_control_i,
  input wire logic [31:0] pin_in_i,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_oe_n_o,
  output logic [NUM_INPUTS-1:0] periph_in_o,
  output logic selection_lock_bit_o,
  output logic one_shot_used_o,
  output logic [NUM_PINS*6-1:0] out_sel_rd_o,
  output logic [NUM_INPUTS*5-1:0] in_sel_rd_o
);
  import pps_pkg::*;

  // index ports need at least one bit, and pin levels arrive on a 32-bit bus
  if (NUM_PINS < 2 || NUM_PINS > 32) begin : g_bad_pins
    $error("pps_top: NUM_PINS must lie between 2 and 32");
  end
  if (NUM_INPUTS < 2) begin : g_bad_inputs
    $error("pps_top: NUM_INPUTS must be at least 2");
  end
  // the output decode covers exactly the codes up to the top code
  if (NUM_SRCS != 33) begin : g_bad_srcs
    $error("pps_top: NUM_SRCS must be 33");
  end

  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic por_s1_reg;
  logic por_s2_reg;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  always_ff @(posedge clock_i or negedge por_n_i) begin
    if (!por_n_i) begin
      por_s1_reg <= 1'b0;
      por_s2_reg <= 1'b0;
    end else begin
      por_s1_reg <= 1'b1;
      por_s2_reg <= por_s1_reg;
    end
  end
  wire logic rst_n = rst_s2_reg;
  wire logic por_n = por_s2_reg;

  ////////////////////////////////////////////////////////////////////////
  // key sequence and lock bit
  pps_key_state_t key_reg;
  pps_key_state_t key_next;
  logic lock_reg;
  logic used_reg;
  logic lock_change;
  logic lock_new;
  logic any_other_wr;

  assign any_other_wr = out_sel_wr_i | in_sel_wr_i;
  assign lock_new = lock_wdata_i[`PPS_LOCK_BIT];
  // with the one-shot option, once set the lock sticks and no clear is accepted
  assign lock_change = lock_wr_i && !any_other_wr && key_reg == PPS_ARMED &&
                       lock_new != lock_reg &&
                       !(one_shot_lock_config_i && used_reg);

  // idle cycles keep the sequence; only writes move it
  always_comb begin
    key_next = key_reg;
    if (any_other_wr) begin
      // a selector write between key writes cancels the sequence
      key_next = PPS_IDLE;
    end else if (lock_wr_i) begin
      unique case (key_reg)
        PPS_IDLE: begin
          if (lock_wdata_i == `PPS_KEY1) begin
            key_next = PPS_KEY1_SEEN;
          end else begin
            key_next = PPS_IDLE;
          end
        end
        PPS_KEY1_SEEN: begin
          if (lock_wdata_i == `PPS_KEY2) begin
            key_next = PPS_ARMED;
          end else if (lock_wdata_i == `PPS_KEY1) begin
            key_next = PPS_KEY1_SEEN;
          end else begin
            key_next = PPS_IDLE;
          end
        end
        PPS_ARMED: begin
          // the write after the keys spends the sequence whatever it holds
          if (lock_wdata_i == `PPS_KEY1) begin
            key_next = PPS_KEY1_SEEN;
          end else begin
            key_next = PPS_IDLE;
          end
        end
        default: begin
          key_next = PPS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      key_reg <= PPS_IDLE;
    end else begin
      key_reg <= key_next;
    end
  end

  // lock state lives in the power-on domain, surviving other resets and sleep
  always_ff @(posedge clock_i or negedge por_n) begin
    if (!por_n) begin
      lock_reg <= 1'b0;
    end else if (lock_change) begin
      lock_reg <= lock_new;
    end
  end

  // one-shot bookkeeping: the first accepted set spends the single change
  always_ff @(posedge clock_i or negedge por_n) begin
    if (!por_n) begin
      used_reg <= 1'b0;
    end else if (lock_change && lock_new) begin
      used_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // selector storage, power-on domain only
  logic [5:0] out_sel_reg [NUM_PINS];
  logic [4:0] in_sel_reg [NUM_INPUTS];

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_out
      always_ff @(posedge clock_i or negedge por_n) begin
        if (!por_n) begin
          out_sel_reg[g] <= `PPS_OUT_DEFAULT;
        end else if (out_sel_wr_i && !lock_reg &&
                     out_sel_idx_i == ($clog2(NUM_PINS))'(g)) begin
          out_sel_reg[g] <= out_sel_wdata_i;
        end
      end

      logic [5:0] code;
      logic drv;
      logic ovr;
      logic ovr_val;
      assign code = out_sel_reg[g];
      // codes 1..32 index peripheral source code; zero and above max drive low with no override
      always_comb begin
        drv = 1'b0;
        ovr = 1'b0;
        ovr_val = 1'b0;
        if (code != 6'h00 && code <= `PPS_CODE_MAX) begin
          drv = periph_out_i[code];
          ovr = periph_oe_ovr_i[code];
          ovr_val = periph_oe_val_i[code];
        end
      end

      always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          pin_out_o[g] <= 1'b0;
        end else begin
          pin_out_o[g] <= drv;
        end
      end

      // pin_direction_control high means input, so drive stays off unless the selected source sets its override
      always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          pin_oe_n_o[g] <= 1'b1;
        end else if (ovr) begin
          // self-driving peripherals take the driver over
          pin_oe_n_o[g] <= ~ovr_val;
        end else begin
          pin_oe_n_o[g] <= pin_direction_control_i[g];
        end
      end

      always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          out_sel_rd_o[g*6 +: 6] <= 6'h00;
        end else begin
          out_sel_rd_o[g*6 +: 6] <= out_sel_reg[g];
        end
      end
    end

    for (g = 0; g < NUM_INPUTS; g++) begin : g_in
      always_ff @(posedge clock_i or negedge por_n) begin
        if (!por_n) begin
          in_sel_reg[g] <= `PPS_IN_DEFAULT;
        end else if (in_sel_wr_i && !lock_reg &&
                     in_sel_idx_i == ($clog2(NUM_INPUTS))'(g)) begin
          in_sel_reg[g] <= in_sel_wdata_i;
        end
      end

      logic [1:0] port;
      logic [2:0] pin;
      assign port = in_sel_reg[g][`PPS_PORT_MSB:`PPS_PORT_LSB];
      assign pin = in_sel_reg[g][`PPS_PIN_MSB:`PPS_PIN_LSB];

      always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          periph_in_o[g] <= 1'b0;
        end else begin
          periph_in_o[g] <= pin_in_i[{port, pin}];
        end
      end

      always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          in_sel_rd_o[g*5 +: 5] <= 5'h00;
        end else begin
          in_sel_rd_o[g*5 +: 5] <= in_sel_reg[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // status outputs
  // sleep_i is deliberately unused: selections and lock hold through sleep
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      selection_lock_bit_o <= 1'b0;
    end else begin
      selection_lock_bit_o <= lock_reg;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      one_shot_used_o <= 1'b0;
    end else begin
      one_shot_used_o <= used_reg;
    end
  end
endmodule
`default_nettype wire

/* File: design/pps_defs.svh */
/*
  constants for the pin selection fabric: codes, field positions, keys, defaults.
  assumes inclusion by bare name from design files.
*/
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH
`define PPS_KEY1 8'h55
`define PPS_KEY2 8'haa
`define PPS_LOCK_BIT 0
`define PPS_PORT_MSB 4
`define PPS_PORT_LSB 3
`define PPS_PIN_MSB 2
`define PPS_PIN_LSB 0
`define PPS_OUT_DEFAULT 6'h00
`define PPS_IN_DEFAULT 5'h00
`define PPS_CODE_SERIAL_DATA 6'h14
`define PPS_CODE_SERIAL_CLK 6'h13
`define PPS_CODE_SYNC_DATA 6'h10
`define PPS_CODE_SYNC_CLK 6'h0f
`define PPS_CODE_MAX 6'h20
`endif

/* File: design/pps_pkg.sv */
/*
  types for the pin selection fabric.
  assumes nothing of its surroundings.
*/
package pps_pkg;
  typedef enum logic [1:0] {
    PPS_IDLE = 2'b00,
    PPS_KEY1_SEEN = 2'b01,
    PPS_ARMED = 2'b11
  } pps_key_state_t;
endpackage

/* File: test/pps_checker.sv */
/* assertions on the pin select top ports.
   assumes binding to pps_top and one clock. */
`timescale 1ns/1ps
`default_nettype none
module pps_checker #(parameter int NUM_PINS = 18, parameter int NUM_SRCS = 33,
  parameter int NUM_INPUTS = 8) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire logic one_shot_lock_config_i,
  input wire logic lock_wr_i,
  input wire logic [7:0] lock_wdata_i,
  input wire logic out_sel_wr_i,
  input wire logic [$clog2(NUM_PINS)-1:0] out_sel_idx_i,
  input wire logic [5:0] out_sel_wdata_i,
  input wire logic in_sel_wr_i,
  input wire logic [$clog2(NUM_INPUTS)-1:0] in_sel_idx_i,
  input wire logic [4:0] in_sel_wdata_i,
  input wire logic [NUM_SRCS-1:0] periph_out_i,
  input wire logic [31:0] pin_in_i,
  input wire logic [NUM_PINS-1:0] pin_out_o,
  input wire logic [NUM_INPUTS-1:0] periph_in_o,
  input wire logic selection_lock_bit_o,
  input wire logic [NUM_PINS*6-1:0] out_sel_rd_o,
  input wire logic [NUM_INPUTS*5-1:0] in_sel_rd_o
);
  logic [2:0] up_reg;
  logic [NUM_SRCS-1:0] periph_d_reg;
  logic [31:0] pin_d_reg;
  // skip the edges while reset leaves the synchroniser and outputs refill
  always_ff @(posedge clock_i or negedge rst_n_i or negedge por_n_i) begin
    if (!rst_n_i || !por_n_i) up_reg <= 3'h0;
    else if (up_reg != 3'h6) up_reg <= up_reg + 3'h1;
  end
  // sources as the design saw them one edge earlier
  always_ff @(posedge clock_i) begin
    periph_d_reg <= periph_out_i;
    pin_d_reg <= pin_in_i;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i || !por_n_i || up_reg != 3'h6);
  property p_freeze; selection_lock_bit_o && (out_sel_wr_i || in_sel_wr_i)
    |=> $stable(out_sel_rd_o) && $stable(in_sel_rd_o); endproperty
  a_freeze: assert property (p_freeze) else $error("selector moved while locked");
  property p_out_wr; !selection_lock_bit_o && out_sel_wr_i
    |-> ##2 out_sel_rd_o[$past(out_sel_idx_i, 2)*6 +: 6] == $past(out_sel_wdata_i, 2);
  endproperty
  a_out_wr: assert property (p_out_wr) else $error("output selector not stored");
  property p_in_wr; !selection_lock_bit_o && in_sel_wr_i && !out_sel_wr_i
    |-> ##2 in_sel_rd_o[$past(in_sel_idx_i, 2)*5 +: 5] == $past(in_sel_wdata_i, 2);
  endproperty
  a_in_wr: assert property (p_in_wr) else $error("input selector not stored");
  property p_key; $changed(selection_lock_bit_o)
    |-> $past(lock_wr_i, 2) && $past(lock_wdata_i[0], 2) == selection_lock_bit_o; endproperty
  a_key: assert property (p_key) else $error("lock moved without lock write");
  property p_one_shot; one_shot_lock_config_i && selection_lock_bit_o
    |=> selection_lock_bit_o; endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot lock cleared");
  property p_disarm; lock_wr_i && (out_sel_wr_i || in_sel_wr_i)
    |=> $stable(selection_lock_bit_o); endproperty
  a_disarm: assert property (p_disarm) else $error("lock moved past selector write");
  property p_route; out_sel_rd_o[5:0] != 6'h00 && out_sel_rd_o[5:0] <= 6'h20
    |-> pin_out_o[0] == periph_d_reg[out_sel_rd_o[5:0]]; endproperty
  a_route: assert property (p_route) else $error("pin 0 wrong source");
  property p_in_route; in_sel_rd_o[4:0] <= 5'h1f
    |-> periph_in_o[0] == pin_d_reg[in_sel_rd_o[4:0]]; endproperty
  a_in_route: assert property (p_in_route) else $error("input 0 wrong pin");
endmodule
bind pps_top pps_checker #(.NUM_PINS(NUM_PINS), .NUM_SRCS(NUM_SRCS),
  .NUM_INPUTS(NUM_INPUTS)) u_checker (.*);
`default_nettype wire

/* File: test/pps_periph_model.sv */
/* stand-in for the peripherals and port pins.
   assumes the bench clock; drives on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module pps_periph_model (
  input wire logic clock_i,
  output logic [32:0] periph_out_o,
  output logic [32:0] periph_oe_ovr_o,
  output logic [32:0] periph_oe_val_o,
  output logic [31:0] pin_in_o
);
  initial begin
    periph_out_o = 33'h0;
    pin_in_o = 32'h0;
  end
  // shifting patterns so no source sits at a fixed level
  always @(negedge clock_i) begin
    periph_out_o <= {periph_out_o[31:0], ~periph_out_o[32]};
    pin_in_o <= {pin_in_o[30:0], ~pin_in_o[31]};
  end
  // serial and sync data and clock (codes 15, 16, 19, 20) drive their own pin drivers
  assign periph_oe_ovr_o = 33'h0_0019_8000;
  assign periph_oe_val_o = periph_out_o;
endmodule
`default_nettype wire

/* File: test/peripheral_pin_select_lock_bench.sv */
/* bench for the pin select fabric: routing, keyed lock, one-shot, resets.
   assumes pps_top, checker and stand-in compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch %0t %h %h", $time, (a), (b)); end end
module peripheral_pin_select_lock_bench;
  logic clock_i, rst_n_i, por_n_i, one_shot_lock_config_i, sleep_i;
  logic lock_wr_i, out_sel_wr_i, in_sel_wr_i, selection_lock_bit_o, one_shot_used_o;
  logic [7:0] lock_wdata_i, periph_in_o;
  logic [4:0] out_sel_idx_i, in_sel_wdata_i;
  logic [5:0] out_sel_wdata_i;
  logic [2:0] in_sel_idx_i;
  logic [32:0] periph_out_i, periph_oe_ovr_i, periph_oe_val_i;
  logic [17:0] pin_direction_control_i, pin_out_o, pin_oe_n_o;
  logic [31:0] pin_in_i;
  logic [107:0] out_sel_rd_o;
  logic [39:0] in_sel_rd_o;
  int miscompares = 0;
  int check_count = 0;
  pps_top u_dut (.*);
  pps_periph_model u_model (.clock_i(clock_i), .periph_out_o(periph_out_i),
    .periph_oe_ovr_o(periph_oe_ovr_i), .periph_oe_val_o(periph_oe_val_i), .pin_in_o(pin_in_i));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic wr_lock(input logic [7:0] d);
    @(negedge clock_i) lock_wr_i = 1'b1;
    lock_wdata_i = d;
    @(negedge clock_i) lock_wr_i = 1'b0;
    @(negedge clock_i);
  endtask
  task automatic keyed(input logic v);
    wr_lock(8'h55);
    wr_lock(8'haa);
    wr_lock({7'h0, v});
  endtask
  task automatic wr_out(input int i, input logic [5:0] c);
    @(negedge clock_i) out_sel_wr_i = 1'b1;
    out_sel_idx_i = 5'(i);
    out_sel_wdata_i = c;
    @(negedge clock_i) out_sel_wr_i = 1'b0;
    @(negedge clock_i);
  endtask
  task automatic wr_in(input int i, input logic [4:0] c);
    @(negedge clock_i) in_sel_wr_i = 1'b1;
    in_sel_idx_i = 3'(i);
    in_sel_wdata_i = c;
    @(negedge clock_i) in_sel_wr_i = 1'b0;
    @(negedge clock_i);
  endtask
  task automatic reset_pulse(input logic por);
    @(negedge clock_i) por_n_i = !por;
    rst_n_i = 1'b0;
    repeat (6) @(negedge clock_i);
    por_n_i = 1'b1;
    rst_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
  endtask
  task automatic finish_test;
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {rst_n_i, por_n_i} = 2'h0;
    {one_shot_lock_config_i, sleep_i, lock_wr_i, out_sel_wr_i, in_sel_wr_i} = 5'h0;
    {lock_wdata_i, out_sel_idx_i, out_sel_wdata_i, in_sel_idx_i, in_sel_wdata_i} = 27'h0;
    pin_direction_control_i = 18'h2aaaa;
    reset_pulse(1'b1);
    `CHK({out_sel_rd_o, in_sel_rd_o, selection_lock_bit_o}, 149'h0)
    for (int c = 1; c <= 32; c++) begin
      wr_out(c % 18, 6'(c));
      wr_out(0, 6'(c));
      `CHK(out_sel_rd_o[(c % 18)*6 +: 6], 6'(c))
    end
    pin_direction_control_i = 18'h15555;
    wr_out(1, 6'h14);
    wr_in(1, 5'h01);
    wr_in(0, 5'h10);
    wr_in(2, 5'h05);
    `CHK({in_sel_rd_o[14:0]}, {5'h05, 5'h01, 5'h10})
    wr_lock(8'h01);
    `CHK(selection_lock_bit_o, 1'b0)
    wr_lock(8'h55);
    wr_out(2, 6'h20);
    wr_lock(8'haa);
    wr_lock(8'h01);
    `CHK(selection_lock_bit_o, 1'b0)
    keyed(1'b1);
    `CHK(selection_lock_bit_o, 1'b1)
    wr_out(2, 6'h01);
    wr_in(0, 5'h00);
    `CHK({out_sel_rd_o[17:12], in_sel_rd_o[4:0]}, {6'h20, 5'h10})
    keyed(1'b0);
    `CHK(selection_lock_bit_o, 1'b0)
    keyed(1'b1);
    sleep_i = 1'b1;
    repeat (4) @(negedge clock_i);
    `CHK({out_sel_rd_o[17:12], selection_lock_bit_o}, {6'h20, 1'b1})
    sleep_i = 1'b0;
    reset_pulse(1'b0);
    `CHK({out_sel_rd_o[17:12], selection_lock_bit_o}, {6'h20, 1'b1})
    one_shot_lock_config_i = 1'b1;
    keyed(1'b0);
    `CHK(selection_lock_bit_o, 1'b1)
    reset_pulse(1'b1);
    `CHK({out_sel_rd_o, selection_lock_bit_o, one_shot_used_o}, 110'h0)
    keyed(1'b1);
    keyed(1'b0);
    `CHK(selection_lock_bit_o, 1'b1)
    finish_test();
  end
endmodule
`default_nettype wire
